// >>> hdl/qqif_pkg.sv
// Package: register map, field layout, opcodes and lane encodings of the host framer
package qqif_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_MODE = 8'h08;
  localparam logic [7:0] REG_LEN = 8'h0c;
  localparam logic [7:0] REG_TXDATA = 8'h10;
  localparam logic [7:0] REG_RXDATA = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int CTL_OP_LSB = 0;
  localparam int CTL_CMDW_LSB = 8;
  localparam int CTL_ADRW_LSB = 10;
  localparam int CTL_DATW_LSB = 12;
  localparam int CTL_AEN_BIT = 14;
  localparam int CTL_MEN_BIT = 15;
  localparam int CTL_RD_BIT = 16;
  localparam int CTL_DUM_LSB = 17;
  localparam int CTL_GO_BIT = 31;

  // ----------------------------------------------------------------
  // Status word fields
  // ----------------------------------------------------------------
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_TXF_BIT = 1;
  localparam int STS_RXV_BIT = 2;
  localparam int STS_DONE_BIT = 3;
  localparam int STS_ALIGN_BIT = 4;
  localparam int STS_LEN_BIT = 5;
  localparam int STS_SEC0_BIT = 6;

  // ----------------------------------------------------------------
  // Lane widths, opcodes, reset values
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    QQIF_W1 = 2'h0,
    QQIF_W2 = 2'h1,
    QQIF_W4 = 2'h2
  } qqif_width_t;

  localparam logic [7:0] OP_WORD_READ = 8'he7;
  localparam logic [7:0] OP_OCTAL_READ = 8'he3;
  localparam logic [7:0] OP_WRAP_SET = 8'h77;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_SEC_PROG = 8'h42;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_SEC_READ = 8'h48;
  localparam logic [15:0] WRAP_LEN = 16'h0004;
  localparam logic [15:0] WRAP_W_BYTE_LEFT = 16'h0002;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Shifts per byte minus one for a lane width
  function automatic logic [2:0] qqif_steps(input logic [1:0] w);
    logic [2:0] s;
    s = 3'h7;
    if (w == QQIF_W2) s = 3'h3;
    if (w == QQIF_W4) s = 3'h1;
    return s;
  endfunction : qqif_steps

  // Lanes driven for a lane width
  function automatic logic [3:0] qqif_mask(input logic [1:0] w);
    logic [3:0] m;
    m = 4'h1;
    if (w == QQIF_W2) m = 4'h3;
    if (w == QQIF_W4) m = 4'hf;
    return m;
  endfunction : qqif_mask
endpackage : qqif_pkg

// >>> hdl/qqif_lane_if.sv
// Interface: byte load, shift and capture between framer engine and lane shifter
`timescale 1ns/1ps
interface qqif_lane_if;
  logic ld;
  logic [7:0] ld_byte;
  logic sh;
  logic smp;
  logic [1:0] width;
  logic [3:0] lanes_in;
  logic [3:0] lanes_out;
  logic [7:0] cap_next;
  modport eng (output ld, ld_byte, sh, smp, width, lanes_in, input lanes_out, cap_next);
  modport sd (input ld, ld_byte, sh, smp, width, lanes_in, output lanes_out, cap_next);
endinterface : qqif_lane_if

// >>> hdl/qqif_lane_shifter.sv
// Lane shifter: splits a byte over one, two or four lanes and gathers read bytes
`timescale 1ns/1ps
module qqif_lane_shifter
  import qqif_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  qqif_lane_if.sd lane
);
  logic [7:0] tx_sh_ff;
  logic [7:0] rx_sh_ff;

  // ----------------------------------------------------------------
  // Transmit: upper bits go out first
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tx_sh_ff <= RST_BYTE;
    end else if (lane.ld) begin
      tx_sh_ff <= lane.ld_byte;
    end else if (lane.sh) begin
      case (lane.width)
        QQIF_W4: tx_sh_ff <= {tx_sh_ff[3:0], 4'h0};
        QQIF_W2: tx_sh_ff <= {tx_sh_ff[5:0], 2'h0};
        default: tx_sh_ff <= {tx_sh_ff[6:0], 1'h0};
      endcase
    end
  end

  always_comb begin
    case (lane.width)
      QQIF_W4: lane.lanes_out = tx_sh_ff[7:4];
      QQIF_W2: lane.lanes_out = {2'h0, tx_sh_ff[7:6]};
      default: lane.lanes_out = {3'h0, tx_sh_ff[7]};
    endcase
  end

  // ----------------------------------------------------------------
  // Receive: single-lane data returns on lane1
  // ----------------------------------------------------------------
  always_comb begin
    case (lane.width)
      QQIF_W4: lane.cap_next = {rx_sh_ff[3:0], lane.lanes_in};
      QQIF_W2: lane.cap_next = {rx_sh_ff[5:0], lane.lanes_in[1:0]};
      default: lane.cap_next = {rx_sh_ff[6:0], lane.lanes_in[1]};
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rx_sh_ff <= RST_BYTE;
    end else if (lane.smp) begin
      rx_sh_ff <= lane.cap_next;
    end
  end
endmodule : qqif_lane_shifter

// >>> hdl/qqif_host.sv
// Host framer: builds opcode, address, mode, dummy and data phases on one, two or four lanes
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps
// How it works
// - Quad bytes take two clocks, upper nibble first, bit 7 on lane3.
// - Quad I/O address and mode byte go four bits per clock, high nibble first.
// - Word quad I/O read is only started with an even address.
// - Octal word read needs low four address bits zero; no dummy clocks.
// - Wrap setting sends eight quad clocks; only the seventh carries wrap bits.
// - Program sends one to 256 bytes; extra bytes wrap within the page. Here only a zero length is refused; REG_LEN takes up to 65535.
// - Every byte travels most significant bit first on any lane count.
// - Prefer security registers one to three; register zero is reserved.
// - Four-line command mode sends opcode, address and data on all lanes.
// - Quad output read: one-lane opcode and address, dummy byte, quad data.
// - Dual address pairs: odd bits on lane1, even on lane0, high first.
// - Raising select ends every instruction.
module qqif_host
  import qqif_pkg::*;
#(
  parameter int LANE_CLK_HALF = 4
) (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RDATA,
  output logic O_SEL_N,
  output logic O_SCLK,
  input wire logic [3:0] I_LANE,
  output logic [3:0] O_LANE,
  output logic [3:0] O_LANE_OE
);
  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // Input sync takes two cycles, so each clock half needs at least three
  if (LANE_CLK_HALF < 3 || LANE_CLK_HALF > 255) begin : g_bad_half
    $error("LANE_CLK_HALF out of range");
  end

  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_CMD = 7'b000_0010,
    ST_ADDR = 7'b000_0100,
    ST_MODE = 7'b000_1000,
    ST_DUMMY = 7'b001_0000,
    ST_DATA = 7'b010_0000,
    ST_END = 7'b100_0000
  } qqif_state_t;

  localparam logic [7:0] HALF_TC = 8'(LANE_CLK_HALF - 1);

  qqif_state_t st_ff;
  qqif_state_t nxt_st;
  logic [31:0] ctrl_ff;
  logic [23:0] addr_ff;
  logic [7:0] mode_ff;
  logic [15:0] len_ff;
  logic [7:0] tx_data_ff;
  logic tx_full_ff;
  logic [7:0] rx_data_ff;
  logic rx_valid_ff;
  logic done_ff;
  logic err_align_ff;
  logic err_len_ff;
  logic warn_sec0_ff;
  logic wait_tx_ff;
  logic [7:0] div_ff;
  logic [2:0] bit_cnt_ff;
  logic [1:0] aidx_ff;
  logic [4:0] dummy_ff;
  logic [3:0] in_meta_ff;
  logic [3:0] in_sync_ff;
  logic [31:0] rdata_ff;
  logic sel_n_ff;
  logic sclk_ff;
  logic [3:0] lane_o_ff;
  logic [3:0] lane_oe_ff;

  logic [1:0] cmd_w;
  logic [1:0] adr_w;
  logic [1:0] dat_w;
  logic cfg_rd;
  logic is_wrap;
  logic running;
  logic tick;
  logic fall;
  logic stall;
  logic start_req;
  logic bad_align;
  logic bad_len;
  logic start_ok;
  logic ld;
  logic [7:0] ld_byte;
  logic sh;
  logic smp;
  logic take_tx;
  logic push_rx;
  logic set_wait;
  logic to_post;
  logic to_data;
  logic data_byte;
  logic [7:0] wrap_byte;
  logic [1:0] st_w;
  logic [1:0] nxt_w;

  qqif_lane_if lane ();

  qqif_lane_shifter u_shifter (
    .i_clock(I_CLOCK),
    .i_rst(I_RST),
    .lane(lane.sd)
  );

  assign cmd_w = ctrl_ff[CTL_CMDW_LSB +: 2];
  assign adr_w = ctrl_ff[CTL_ADRW_LSB +: 2];
  assign dat_w = ctrl_ff[CTL_DATW_LSB +: 2];
  assign cfg_rd = ctrl_ff[CTL_RD_BIT];
  assign is_wrap = ctrl_ff[CTL_OP_LSB +: 8] == OP_WRAP_SET;

  // ----------------------------------------------------------------
  // Start checks
  // ----------------------------------------------------------------
  assign start_req = I_WR && I_ADDR == REG_CTRL && I_WDATA[CTL_GO_BIT] && st_ff == ST_IDLE;
  assign bad_align = (I_WDATA[7:0] == OP_WORD_READ && addr_ff[0]) ||
    (I_WDATA[7:0] == OP_OCTAL_READ && addr_ff[3:0] != 4'h0);
  assign bad_len = len_ff == 16'h0000 && (I_WDATA[7:0] == OP_PAGE_PROG ||
    I_WDATA[7:0] == OP_QUAD_PROG || I_WDATA[7:0] == OP_SEC_PROG);
  assign start_ok = start_req && !bad_align && !bad_len;

  // ----------------------------------------------------------------
  // Lane clock divider
  // ----------------------------------------------------------------
  assign running = st_ff != ST_IDLE;
  assign tick = running && div_ff == HALF_TC;
  assign fall = tick && sclk_ff && st_ff != ST_END;
  // Holding the clock low is the only back-pressure the link has
  assign stall = st_ff == ST_DATA && (cfg_rd ? rx_valid_ff : wait_tx_ff);

  always_ff @(posedge I_CLOCK) begin
    if (I_RST || !running || tick) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      sclk_ff <= 1'b0;
    end else if (tick && st_ff != ST_END) begin
      sclk_ff <= sclk_ff ? 1'b0 : !stall;
    end
  end

  // ----------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------
  assign wrap_byte = (st_ff == ST_DATA && len_ff == WRAP_W_BYTE_LEFT) ?
    {1'b0, mode_ff[6:4], 4'h0} : RST_BYTE;

  always_comb begin
    nxt_st = st_ff;
    ld = 1'b0;
    ld_byte = RST_BYTE;
    sh = 1'b0;
    smp = 1'b0;
    take_tx = 1'b0;
    push_rx = 1'b0;
    set_wait = 1'b0;
    to_post = 1'b0;
    to_data = 1'b0;
    data_byte = 1'b0;
    if (start_ok) begin
      nxt_st = ST_CMD;
      ld = 1'b1;
      ld_byte = I_WDATA[7:0];
    end
    if (wait_tx_ff && tx_full_ff) begin
      ld = 1'b1;
      ld_byte = tx_data_ff;
      take_tx = 1'b1;
    end
    if (fall) begin
      smp = st_ff == ST_DATA && cfg_rd;
      if (st_ff == ST_DUMMY) begin
        to_data = dummy_ff == 5'h01;
      end else if (bit_cnt_ff != 3'h0) begin
        sh = 1'b1;
      end else begin
        case (st_ff)
          ST_CMD: begin
            if (ctrl_ff[CTL_AEN_BIT]) begin
              nxt_st = ST_ADDR;
              ld = 1'b1;
              ld_byte = addr_ff[23:16];
            end else begin
              to_post = 1'b1;
            end
          end
          ST_ADDR: begin
            if (aidx_ff != 2'h0) begin
              ld = 1'b1;
              ld_byte = (aidx_ff == 2'h2) ? addr_ff[15:8] : addr_ff[7:0];
            end else if (ctrl_ff[CTL_MEN_BIT]) begin
              nxt_st = ST_MODE;
              ld = 1'b1;
              ld_byte = mode_ff;
            end else begin
              to_post = 1'b1;
            end
          end
          ST_MODE: to_post = 1'b1;
          ST_DATA: begin
            push_rx = cfg_rd;
            if (len_ff == 16'h0001) begin
              nxt_st = ST_END;
            end else begin
              data_byte = 1'b1;
            end
          end
          default: nxt_st = st_ff;
        endcase
      end
      if (to_post) begin
        if (ctrl_ff[CTL_DUM_LSB +: 5] != 5'h00) begin
          nxt_st = ST_DUMMY;
        end else begin
          to_data = 1'b1;
        end
      end
      if (to_data) begin
        if (len_ff == 16'h0000) begin
          nxt_st = ST_END;
        end else begin
          nxt_st = ST_DATA;
          data_byte = 1'b1;
        end
      end
      if (data_byte && !cfg_rd) begin
        if (is_wrap) begin
          ld = 1'b1;
          ld_byte = wrap_byte;
        end else if (tx_full_ff) begin
          ld = 1'b1;
          ld_byte = tx_data_ff;
          take_tx = 1'b1;
        end else begin
          set_wait = 1'b1;
        end
      end
    end
  end

  always_comb begin
    case (nxt_st)
      ST_ADDR, ST_MODE: nxt_w = adr_w;
      ST_DATA: nxt_w = dat_w;
      default: nxt_w = cmd_w;
    endcase
    case (st_ff)
      ST_ADDR, ST_MODE: st_w = adr_w;
      ST_DATA: st_w = dat_w;
      default: st_w = cmd_w;
    endcase
  end

  assign lane.ld = ld;
  assign lane.ld_byte = ld_byte;
  assign lane.sh = sh;
  assign lane.smp = smp;
  assign lane.width = st_w;
  assign lane.lanes_in = in_sync_ff;

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      st_ff <= ST_IDLE;
    end else if (st_ff == ST_END && tick) begin
      st_ff <= ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      bit_cnt_ff <= 3'h0;
    end else if (start_ok) begin
      bit_cnt_ff <= qqif_steps(I_WDATA[CTL_CMDW_LSB +: 2]);
    end else if (ld || to_data) begin
      // Reads enter data with no load, so the count is armed here
      bit_cnt_ff <= qqif_steps(nxt_w);
    end else if (sh) begin
      bit_cnt_ff <= bit_cnt_ff - 3'h1;
    end else if (smp) begin
      bit_cnt_ff <= qqif_steps(dat_w);
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      aidx_ff <= 2'h0;
      dummy_ff <= 5'h00;
      wait_tx_ff <= 1'b0;
    end else begin
      if (nxt_st == ST_ADDR && st_ff != ST_ADDR) begin
        aidx_ff <= 2'h2;
      end else if (ld && st_ff == ST_ADDR) begin
        aidx_ff <= aidx_ff - 2'h1;
      end
      if (nxt_st == ST_DUMMY && st_ff != ST_DUMMY) begin
        dummy_ff <= ctrl_ff[CTL_DUM_LSB +: 5];
      end else if (fall && st_ff == ST_DUMMY) begin
        dummy_ff <= dummy_ff - 5'h01;
      end
      if (set_wait) begin
        wait_tx_ff <= 1'b1;
      end else if (take_tx) begin
        wait_tx_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pins: select, clock, lanes
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      sel_n_ff <= 1'b1;
    end else if (start_ok) begin
      sel_n_ff <= 1'b0;
    end else if (nxt_st == ST_END) begin
      sel_n_ff <= 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      lane_o_ff <= 4'h0;
      lane_oe_ff <= 4'h0;
    end else begin
      lane_o_ff <= lane.lanes_out;
      if (st_ff == ST_CMD || st_ff == ST_ADDR || st_ff == ST_MODE ||
          (st_ff == ST_DATA && !cfg_rd)) begin
        lane_oe_ff <= qqif_mask(st_w);
      end else begin
        lane_oe_ff <= 4'h0;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      in_meta_ff <= 4'h0;
      in_sync_ff <= 4'h0;
    end else begin
      in_meta_ff <= I_LANE;
      in_sync_ff <= in_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      ctrl_ff <= RST_CTRL;
      addr_ff <= 24'h00_0000;
      mode_ff <= RST_BYTE;
      len_ff <= 16'h0000;
    end else begin
      if (start_ok) begin
        ctrl_ff <= I_WDATA;
        if (I_WDATA[7:0] == OP_WRAP_SET) begin
          ctrl_ff[CTL_RD_BIT] <= 1'b0;
        end
      end
      if (I_WR && I_ADDR == REG_ADDR && st_ff == ST_IDLE) begin
        addr_ff <= I_WDATA[23:0];
      end
      if (I_WR && I_ADDR == REG_MODE && st_ff == ST_IDLE) begin
        mode_ff <= I_WDATA[7:0];
      end
      if (start_ok && I_WDATA[7:0] == OP_WRAP_SET) begin
        len_ff <= WRAP_LEN;
      end else if (fall && st_ff == ST_DATA && bit_cnt_ff == 3'h0) begin
        len_ff <= len_ff - 16'h0001;
      end else if (I_WR && I_ADDR == REG_LEN && st_ff == ST_IDLE) begin
        len_ff <= I_WDATA[15:0];
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      tx_data_ff <= RST_BYTE;
      tx_full_ff <= 1'b0;
      rx_data_ff <= RST_BYTE;
      rx_valid_ff <= 1'b0;
    end else begin
      if (I_WR && I_ADDR == REG_TXDATA) begin
        tx_data_ff <= I_WDATA[7:0];
        tx_full_ff <= 1'b1;
      end else if (take_tx) begin
        tx_full_ff <= 1'b0;
      end
      if (push_rx) begin
        rx_data_ff <= lane.cap_next;
        rx_valid_ff <= 1'b1;
      end else if (I_RD && I_ADDR == REG_RXDATA) begin
        rx_valid_ff <= 1'b0;
      end
    end
  end

  // Sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      done_ff <= 1'b0;
      err_align_ff <= 1'b0;
      err_len_ff <= 1'b0;
      warn_sec0_ff <= 1'b0;
    end else begin
      if (st_ff == ST_END && tick) begin
        done_ff <= 1'b1;
      end else if (I_WR && I_ADDR == REG_STATUS && I_WDATA[STS_DONE_BIT]) begin
        done_ff <= 1'b0;
      end
      if (start_req && bad_align) begin
        err_align_ff <= 1'b1;
      end else if (I_WR && I_ADDR == REG_STATUS && I_WDATA[STS_ALIGN_BIT]) begin
        err_align_ff <= 1'b0;
      end
      if (start_req && bad_len) begin
        err_len_ff <= 1'b1;
      end else if (I_WR && I_ADDR == REG_STATUS && I_WDATA[STS_LEN_BIT]) begin
        err_len_ff <= 1'b0;
      end
      if (start_ok && addr_ff[23:8] == 16'h0000 && (I_WDATA[7:0] == OP_SEC_PROG ||
          I_WDATA[7:0] == OP_SEC_ERASE || I_WDATA[7:0] == OP_SEC_READ)) begin
        warn_sec0_ff <= 1'b1;
      end else if (I_WR && I_ADDR == REG_STATUS && I_WDATA[STS_SEC0_BIT]) begin
        warn_sec0_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      rdata_ff <= 32'h0000_0000;
    end else if (I_RD) begin
      case (I_ADDR)
        REG_CTRL: rdata_ff <= ctrl_ff;
        REG_ADDR: rdata_ff <= {8'h00, addr_ff};
        REG_MODE: rdata_ff <= {24'h00_0000, mode_ff};
        REG_LEN: rdata_ff <= {16'h0000, len_ff};
        REG_RXDATA: rdata_ff <= {24'h00_0000, rx_data_ff};
        REG_STATUS: rdata_ff <= {25'h000_0000, warn_sec0_ff, err_len_ff, err_align_ff,
          done_ff, rx_valid_ff, tx_full_ff, running};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  assign O_RDATA = rdata_ff;
  assign O_SEL_N = sel_n_ff;
  assign O_SCLK = sclk_ff;
  assign O_LANE = lane_o_ff;
  assign O_LANE_OE = lane_oe_ff;
endmodule : qqif_host

// >>> tb/qqif_host_sva.sv
// Checker: link clock, select and lane timing at the host framer ports
`timescale 1ns/1ps
module qqif_host_sva #(
  parameter int LANE_CLK_HALF = 4
) (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic O_SEL_N,
  input wire logic O_SCLK,
  input wire logic [3:0] O_LANE,
  input wire logic [3:0] O_LANE_OE
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  // --------------------------------------------------------------
  // Link framing
  // --------------------------------------------------------------
  // Repeat counts assume the default half period of four cycles
  property p_sclk_idle;
    O_SEL_N |-> !O_SCLK;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("clock runs while deselected");
  property p_first_rise;
    $fell(O_SEL_N) |-> !O_SCLK [*4] ##1 O_SCLK;
  endproperty
  a_first_rise: assert property (p_first_rise) else $error("first clock late or early");
  property p_high;
    $rose(O_SCLK) |-> O_SCLK [*4] ##1 !O_SCLK;
  endproperty
  a_high: assert property (p_high) else $error("clock high phase wrong");
  property p_low;
    $fell(O_SCLK) |-> !O_SCLK [*4];
  endproperty
  a_low: assert property (p_low) else $error("clock low phase short");
  property p_lane_stable;
    O_SCLK |-> $stable({O_LANE, O_LANE_OE});
  endproperty
  a_lane_stable: assert property (p_lane_stable) else $error("lanes move while clock high");
  property p_oe_sel;
    O_SEL_N && $past(O_SEL_N) |-> O_LANE_OE == 4'h0;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("lanes driven while deselected");
  property p_oe_shape;
    O_LANE_OE inside {4'h0, 4'h1, 4'h3, 4'hf};
  endproperty
  a_oe_shape: assert property (p_oe_shape) else $error("odd lane enable set");
  property p_cmd_drive;
    $fell(O_SEL_N) |-> ##4 O_LANE_OE[0];
  endproperty
  a_cmd_drive: assert property (p_cmd_drive) else $error("opcode lane not driven");
endmodule : qqif_host_sva

bind qqif_host qqif_host_sva #(.LANE_CLK_HALF(LANE_CLK_HALF)) sva_u (.I_CLOCK(I_CLOCK),
  .I_RST(I_RST), .O_SEL_N(O_SEL_N), .O_SCLK(O_SCLK), .O_LANE(O_LANE), .O_LANE_OE(O_LANE_OE));

// >>> tb/qqif_flash_model.sv
// Flash model: logs lane nibbles, shifts a read byte out on its lanes
`timescale 1ns/1ps
module qqif_flash_model (
  input wire logic i_sel_n,
  input wire logic i_sclk,
  input wire logic [3:0] i_lane,
  input wire logic [2:0] i_rw,
  input wire logic [7:0] i_beg,
  input wire logic [7:0] i_byte,
  output logic [3:0] o_lane,
  output logic [3:0] o_oe
);
  logic [3:0] nib[$];
  logic [7:0] sh = 8'h00;
  int n = 0;
  initial o_oe = 4'h0;
  initial o_lane = 4'h0;
  // --------------------------------------------------------------
  // Input and output phases
  // --------------------------------------------------------------
  always @(negedge i_sel_n) begin
    nib = {};
    n = 0;
  end
  always @(posedge i_sclk) begin
    if (!i_sel_n) begin
      nib.push_back(i_lane);
      n++;
    end
  end
  // Begin count set per read, so one model covers every dummy length
  always @(negedge i_sclk or posedge i_sel_n) begin
    if (i_sel_n || i_rw == 3'h0 || n < i_beg) begin
      o_oe <= 4'h0;
    end else begin
      if (((n - i_beg) * i_rw) % 8 == 0) sh = i_byte;
      o_oe <= i_rw == 3'h4 ? 4'hf : i_rw == 3'h2 ? 4'h3 : 4'h2;
      o_lane <= i_rw == 3'h4 ? sh[7:4] : {2'h0, sh[7:6]};
      sh = sh << i_rw;
    end
  end
endmodule : qqif_flash_model

// >>> tb/quad_qpi_instruction_framing_tb_top.sv
// Testbench: register rows and framed transfers against the flash model
`timescale 1ns/1ps
module quad_qpi_instruction_framing_tb_top;
  import qqif_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d, e;} qqif_reg_row_t;
  typedef struct {logic [31:0] c; logic [2:0] w; logic [7:0] b, d; logic [15:0] n;} qqif_rd_t;
  logic I_CLOCK = 1'b0;
  logic I_RST = 1'b1;
  logic I_WR = 1'b0;
  logic I_RD = 1'b0;
  logic [7:0] I_ADDR = 8'h00;
  logic [31:0] I_WDATA = 32'h0, O_RDATA, s, v;
  logic O_SEL_N, O_SCLK;
  logic [3:0] O_LANE, O_LANE_OE, dl, doe, lane;
  logic [2:0] rw = 3'h0;
  logic [7:0] beg = 8'h00, rb = 8'h00;
  int errors = 0, n_tests = 0, nsel = 0, m, j;
  qqif_reg_row_t regs[4] = '{'{REG_ADDR, 32'h0012_3456, 32'h0012_3456},
    '{REG_MODE, 32'h0000_00a5, 32'h0000_00a5}, '{REG_LEN, 32'h0000_0101, 32'h0000_0101},
    '{8'h1c, 32'hffff_ffff, 32'h0000_0000}};
  qqif_rd_t rows[6] = '{'{32'h8009_e8eb, 3'h4, 8'h14, 8'h5c, 16'h1},
    '{32'h8005_e8e7, 3'h4, 8'h12, 8'h3a, 16'h1},
    '{32'h8001_e8e3, 3'h4, 8'h10, 8'hc6, 16'h1},
    '{32'h8011_606b, 3'h4, 8'h28, 8'h96, 16'h1},
    '{32'h8011_503b, 3'h2, 8'h28, 8'h69, 16'h1},
    '{32'h8001_0005, 3'h1, 8'h08, 8'hb4, 16'h2}};
  always #10 I_CLOCK = ~I_CLOCK;
  always @(negedge O_SEL_N) nsel++;
  // Open lanes float to the pull-up level
  assign lane = (O_LANE & O_LANE_OE) | (dl & doe) | ~(O_LANE_OE | doe);
  qqif_host dut_u (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_SEL_N(O_SEL_N), .O_SCLK(O_SCLK),
    .I_LANE(lane), .O_LANE(O_LANE), .O_LANE_OE(O_LANE_OE));
  qqif_flash_model fm_u (.i_sel_n(O_SEL_N), .i_sclk(O_SCLK), .i_lane(lane), .i_rw(rw),
    .i_beg(beg), .i_byte(rb), .o_lane(dl), .o_oe(doe));
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLOCK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLOCK);
    I_WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge I_CLOCK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLOCK);
    I_RD <= 1'b0;
    #1 s = O_RDATA;
  endtask : rd
  // Polls status; read bytes are checked as they arrive, write bytes refilled
  task automatic go(input logic [31:0] c, input logic [23:0] a, input logic [15:0] n,
    input logic [7:0] tx);
    int k;
    wr(REG_ADDR, {8'h00, a});
    wr(REG_LEN, {16'h0, n});
    wr(REG_TXDATA, {24'h0, tx});
    wr(REG_CTRL, c);
    for (k = 0; k < 3000; k++) begin
      rd(REG_STATUS);
      if (s[STS_RXV_BIT]) begin
        rd(REG_RXDATA);
        chk("rx_byte", {24'h0, rb}, s);
      end else if (!s[STS_BUSY_BIT]) begin
        break;
      end else if (!c[CTL_RD_BIT] && !s[STS_TXF_BIT]) begin
        wr(REG_TXDATA, {24'h0, tx});
      end
    end
  endtask : go
  task automatic close_out();
    if (errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    #1000000;
    errors++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge I_CLOCK);
    I_RST <= 1'b0;
    rd(REG_STATUS);
    chk("status_rst", 32'h0, s);
    foreach (regs[i]) begin
      wr(regs[i].a, regs[i].d);
      rd(regs[i].a);
      chk("reg", regs[i].e, s);
    end
    foreach (rows[i]) begin
      rw <= rows[i].w;
      beg <= rows[i].b;
      rb <= rows[i].d;
      go(rows[i].c, 24'h12_3450, rows[i].n, 8'h00);
      if (i < 3) begin
        v = 32'h0;
        for (j = 8; j < 16; j++) v = {v[27:0], fm_u.nib[j]};
        chk("addr_mode", 32'h1234_50a5, v);
      end
    end
    rw <= 3'h0;
    go(32'h8000_6032, 24'h01_2345, 16'h1, 8'ha5);
    v = 32'h0;
    for (j = 0; j < 8; j++) v = {v[30:0], fm_u.nib[j][0]};
    chk("prog_op", 32'h32, v);
    chk("prog_data", 32'ha5, {24'h0, fm_u.nib[32], fm_u.nib[33]});
    chk("prog_clks", 32'd34, 32'(fm_u.nib.size()));
    wr(REG_MODE, 32'h0000_0070);
    go(32'h8000_2077, 24'h0, 16'h0, 8'h00);
    chk("wrap_clks", 32'd16, 32'(fm_u.nib.size()));
    chk("wrap_bits", 32'h7, {28'h0, fm_u.nib[14]});
    m = nsel;
    go(32'h8005_e8e7, 24'h12_3451, 16'h1, 8'h00);
    chk("align_word", 32'h1, {31'h0, s[STS_ALIGN_BIT]});
    wr(REG_STATUS, 32'h78);
    go(32'h8001_e8e3, 24'h12_3458, 16'h1, 8'h00);
    chk("align_octal", 32'h1, {31'h0, s[STS_ALIGN_BIT]});
    wr(REG_STATUS, 32'h78);
    go(32'h8000_6032, 24'h01_2345, 16'h0, 8'h00);
    chk("len_zero", 32'h1, {31'h0, s[STS_LEN_BIT]});
    chk("no_start", 32'(m), 32'(nsel));
    wr(REG_STATUS, 32'h78);
    go(32'h8000_4044, 24'h00_0000, 16'h0, 8'h00);
    chk("sec_zero", 32'h1, {31'h0, s[STS_SEC0_BIT]});
    close_out();
  end
endmodule : quad_qpi_instruction_framing_tb_top
